//--- rtl/uafc_pkg.sv
// Constants and register map of the flow-controlled serial port
package uafc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_TASK_RX_START = 12'h000;
  localparam logic [11:0] OFF_TASK_RX_STOP = 12'h004;
  localparam logic [11:0] OFF_TASK_TX_START = 12'h008;
  localparam logic [11:0] OFF_TASK_TX_STOP = 12'h00c;
  localparam logic [11:0] OFF_TASK_PAUSE = 12'h01c;
  localparam logic [11:0] OFF_EV_PEER_CLEAR = 12'h100;
  localparam logic [11:0] OFF_EV_PEER_NOT_CLEAR = 12'h104;
  localparam logic [11:0] OFF_EV_RX_READY = 12'h108;
  localparam logic [11:0] OFF_EV_TX_READY = 12'h11c;
  localparam logic [11:0] OFF_EV_LINE_FAULT = 12'h124;
  localparam logic [11:0] OFF_EV_RX_TIMEOUT = 12'h144;
  localparam logic [11:0] OFF_EVENT_TASK_LINKS = 12'h200;
  localparam logic [11:0] OFF_IRQ_ENABLE_SET = 12'h304;
  localparam logic [11:0] OFF_IRQ_ENABLE_CLEAR = 12'h308;
  localparam logic [11:0] OFF_FAULT_CAUSE = 12'h480;
  localparam logic [11:0] OFF_PORT_ENABLE = 12'h500;
  localparam logic [11:0] OFF_PIN_SEL_REQ = 12'h508;
  localparam logic [11:0] OFF_PIN_SEL_TX = 12'h50c;
  localparam logic [11:0] OFF_PIN_SEL_CLEAR = 12'h510;
  localparam logic [11:0] OFF_PIN_SEL_RX = 12'h514;
  localparam logic [11:0] OFF_RECEIVE_BYTE = 12'h518;
  localparam logic [11:0] OFF_TRANSMIT_BYTE = 12'h51c;
  localparam logic [11:0] OFF_BIT_RATE = 12'h524;
  localparam logic [11:0] OFF_FRAME_FLOW = 12'h56c;
  // Field positions
  localparam int PSEL_DISC_BIT = 31;
  localparam int CFG_FLOW_BIT = 0;
  localparam int CFG_PARITY_BIT = 1;
  localparam int CFG_TWO_STOP_BIT = 2;
  localparam int CFG_ODD_BIT = 3;
  localparam int LINK_CTS_RXSTART_BIT = 0;
  localparam int LINK_NCTS_RXSTOP_BIT = 1;
  localparam int FLT_OVERRUN_BIT = 0;
  localparam int FLT_PARITY_BIT = 1;
  localparam int FLT_FRAMING_BIT = 2;
  localparam int FLT_BREAK_BIT = 3;
  // Reset values and counts
  localparam logic [3:0] ENABLE_ON = 4'h4;
  localparam logic [31:0] PSEL_RESET = 32'hffffffff;
  localparam logic [15:0] BIT_RATE_RESET = 16'h0364;
  localparam logic [2:0] FIFO_DEPTH = 3'h6;
  localparam logic [2:0] RTS_OFF_LEVEL = 3'h2;
  localparam logic [7:0] RX_TIMEOUT_BITS = 8'h37;
  localparam logic [3:0] FRAME_BASE_BITS = 4'ha;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- rtl/uafc_uart.sv
// Serial port with six-byte receive queue, flow control and AXI4-Lite registers
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
module uafc_uart
  import uafc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd_in,
  input wire logic cts_n_in,
  output logic txd_out,
  output logic txd_oe_n,
  output logic rts_n_out,
  output logic rts_oe_n
);

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic ev_cts;
    logic ev_ncts;
    logic ev_rxrdy;
    logic ev_txrdy;
    logic ev_err;
    logic ev_receiver_timeout_event;
    logic [1:0] links;
    logic [31:0] irq_en;
    logic [3:0] fault;
    logic [3:0] enable;
    logic [31:0] psel_rts;
    logic [31:0] psel_txd;
    logic [31:0] psel_cts;
    logic [31:0] psel_rxd;
    logic [15:0] baud;
    logic [3:0] cfg;
    logic tx_on;
    logic tx_pend;
    logic [7:0] tx_hold;
    logic tx_busy;
    logic [11:0] tx_shift;
    logic [3:0] tx_left;
    logic [15:0] tx_cnt;
    logic rx_on;
    logic rx_drain;
    logic [31:0] rx_tmo;
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_idx;
    logic [7:0] rx_data;
    logic [31:0] low_cnt;
    logic brk_done;
    logic [5:0][7:0] fifo;
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic [2:0] count;
    logic rxd_val;
    logic [7:0] rxd_byte;
    logic rts_block;
    logic cts_prev;
    logic rts_n;
  } uafc_state_s;

  uafc_state_s q;
  uafc_state_s d;

  function automatic logic [31:0] uafc_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] uafc_next(input logic [2:0] p);
    return (p == FIFO_DEPTH - 3'h1) ? 3'h0 : p + 3'h1;
  endfunction

  // Bits of a whole frame, start and stop bits included
  function automatic logic [3:0] uafc_frame_bits(input logic [3:0] cfg);
    return FRAME_BASE_BITS + {3'h0, cfg[CFG_PARITY_BIT]} + {3'h0, cfg[CFG_TWO_STOP_BIT]};
  endfunction

  logic port_en;
  logic flow;
  logic rxd_eff;
  logic cts_eff;
  logic [15:0] div;
  logic wr_fire;
  logic t_rx_start, t_rx_stop, t_tx_start, t_tx_stop, t_pause;
  logic push;
  logic rx_bit;
  logic [31:0] frame_cycles;
  logic [31:0] wv;

  assign port_en = (q.enable == ENABLE_ON);
  assign flow = q.cfg[CFG_FLOW_BIT];
  assign div = (q.baud < 16'h0002) ? 16'h0002 : q.baud;
  assign rxd_eff = (port_en && !q.psel_rxd[PSEL_DISC_BIT]) ? rxd_in : 1'b1;
  // A disconnected clear-to-send is treated as permanently active
  assign cts_eff = (port_en && flow && !q.psel_cts[PSEL_DISC_BIT]) ? cts_n_in : 1'b0;
  assign frame_cycles = 32'(div) * 32'(uafc_frame_bits(q.cfg));
  assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
  assign wv = uafc_merge(32'h0, q.wdata, q.wstrb);
  assign t_rx_start = wr_fire && q.awaddr == OFF_TASK_RX_START && wv[0];
  assign t_rx_stop = wr_fire && q.awaddr == OFF_TASK_RX_STOP && wv[0];
  assign t_tx_start = wr_fire && q.awaddr == OFF_TASK_TX_START && wv[0];
  assign t_tx_stop = wr_fire && q.awaddr == OFF_TASK_TX_STOP && wv[0];
  assign t_pause = wr_fire && q.awaddr == OFF_TASK_PAUSE && wv[0];

  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign txd_out = q.tx_shift[0];
  assign txd_oe_n = !(port_en && !q.psel_txd[PSEL_DISC_BIT]);
  assign rts_n_out = q.rts_n;
  assign rts_oe_n = !(port_en && !q.psel_rts[PSEL_DISC_BIT]);

  always_comb begin
    logic sw_set_rx, sw_stop_rx;
    logic [7:0] cmp;
    logic stop_ok;
    sw_set_rx = 1'b0;
    sw_stop_rx = 1'b0;
    cmp = 8'h0;
    stop_ok = 1'b0;
    push = 1'b0;
    rx_bit = rxd_eff;
    d = q;

    // Bus handshakes
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // Register writes; hardware sets later in this process win over clears
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (q.awaddr)
        OFF_TASK_RX_START, OFF_TASK_RX_STOP, OFF_TASK_TX_START,
        OFF_TASK_TX_STOP, OFF_TASK_PAUSE: d.bresp = RESP_OKAY;
        OFF_EV_PEER_CLEAR: d.ev_cts = wv[0];
        OFF_EV_PEER_NOT_CLEAR: d.ev_ncts = wv[0];
        OFF_EV_RX_READY: d.ev_rxrdy = wv[0];
        OFF_EV_TX_READY: d.ev_txrdy = wv[0];
        OFF_EV_LINE_FAULT: d.ev_err = wv[0];
        OFF_EV_RX_TIMEOUT: d.ev_receiver_timeout_event = wv[0];
        OFF_EVENT_TASK_LINKS: d.links = wv[1:0];
        OFF_IRQ_ENABLE_SET: d.irq_en = q.irq_en | wv;
        OFF_IRQ_ENABLE_CLEAR: d.irq_en = q.irq_en & ~wv;
        OFF_FAULT_CAUSE: d.fault = q.fault & ~wv[3:0];
        OFF_PORT_ENABLE: d.enable = wv[3:0];
        OFF_PIN_SEL_REQ: d.psel_rts = uafc_merge(q.psel_rts, q.wdata, q.wstrb);
        OFF_PIN_SEL_TX: d.psel_txd = uafc_merge(q.psel_txd, q.wdata, q.wstrb);
        OFF_PIN_SEL_CLEAR: d.psel_cts = uafc_merge(q.psel_cts, q.wdata, q.wstrb);
        OFF_PIN_SEL_RX: d.psel_rxd = uafc_merge(q.psel_rxd, q.wdata, q.wstrb);
        OFF_TRANSMIT_BYTE: begin
          d.tx_hold = wv[7:0];
          d.tx_pend = 1'b1;
        end
        OFF_BIT_RATE: d.baud = wv[15:0];
        OFF_FRAME_FLOW: d.cfg = wv[3:0];
        default: d.bresp = RESP_SLVERR;
      endcase
    end

    // Register reads
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 32'h0;
      case (s_axi_araddr)
        OFF_TASK_RX_START, OFF_TASK_RX_STOP, OFF_TASK_TX_START,
        OFF_TASK_TX_STOP, OFF_TASK_PAUSE, OFF_TRANSMIT_BYTE: d.rdata = 32'h0;
        OFF_EV_PEER_CLEAR: d.rdata = {31'h0, q.ev_cts};
        OFF_EV_PEER_NOT_CLEAR: d.rdata = {31'h0, q.ev_ncts};
        OFF_EV_RX_READY: d.rdata = {31'h0, q.ev_rxrdy};
        OFF_EV_TX_READY: d.rdata = {31'h0, q.ev_txrdy};
        OFF_EV_LINE_FAULT: d.rdata = {31'h0, q.ev_err};
        OFF_EV_RX_TIMEOUT: d.rdata = {31'h0, q.ev_receiver_timeout_event};
        OFF_EVENT_TASK_LINKS: d.rdata = {30'h0, q.links};
        OFF_IRQ_ENABLE_SET, OFF_IRQ_ENABLE_CLEAR: d.rdata = q.irq_en;
        OFF_FAULT_CAUSE: d.rdata = {28'h0, q.fault};
        OFF_PORT_ENABLE: d.rdata = {28'h0, q.enable};
        OFF_PIN_SEL_REQ: d.rdata = q.psel_rts;
        OFF_PIN_SEL_TX: d.rdata = q.psel_txd;
        OFF_PIN_SEL_CLEAR: d.rdata = q.psel_cts;
        OFF_PIN_SEL_RX: d.rdata = q.psel_rxd;
        OFF_RECEIVE_BYTE: begin
          d.rdata = {24'h0, q.rxd_byte};
          d.rxd_val = 1'b0;
        end
        OFF_BIT_RATE: d.rdata = {16'h0, q.baud};
        OFF_FRAME_FLOW: d.rdata = {28'h0, q.cfg};
        default: d.rresp = RESP_SLVERR;
      endcase
    end

    // Peer clear-to-send edges; links may turn them into receive tasks
    d.cts_prev = cts_eff;
    if (q.cts_prev && !cts_eff) begin
      d.ev_cts = 1'b1;
      sw_set_rx = q.links[LINK_CTS_RXSTART_BIT];
    end
    if (!q.cts_prev && cts_eff) begin
      d.ev_ncts = 1'b1;
      sw_stop_rx = q.links[LINK_NCTS_RXSTOP_BIT];
    end

    // Transmitter
    if (t_tx_start) begin
      d.tx_on = 1'b1;
    end
    if (t_pause) begin
      d.tx_on = 1'b0;
    end
    if (t_tx_stop) begin
      d.tx_on = 1'b0;
      d.tx_busy = 1'b0;
      d.tx_shift = 12'hfff;
    end else if (q.tx_busy) begin
      // Frame runs to its end regardless of clear-to-send or pause
      if (q.tx_cnt == div - 16'h1) begin
        d.tx_cnt = 16'h0;
        d.tx_shift = {1'b1, q.tx_shift[11:1]};
        d.tx_left = q.tx_left - 4'h1;
        if (q.tx_left == 4'h1) begin
          d.tx_busy = 1'b0;
          d.ev_txrdy = 1'b1;
        end
      end else begin
        d.tx_cnt = q.tx_cnt + 16'h1;
      end
    end else if (q.tx_on && q.tx_pend && port_en && !cts_eff) begin
      d.tx_pend = 1'b0;
      d.tx_busy = 1'b1;
      d.tx_cnt = 16'h0;
      d.tx_left = uafc_frame_bits(q.cfg);
      if (q.cfg[CFG_PARITY_BIT]) begin
        d.tx_shift = {2'b11, ^q.tx_hold ^ q.cfg[CFG_ODD_BIT], q.tx_hold, 1'b0};
      end else begin
        d.tx_shift = {3'b111, q.tx_hold, 1'b0};
      end
    end

    // Receiver run control
    if (t_rx_start || sw_set_rx) begin
      d.rx_on = 1'b1;
      d.rx_drain = 1'b0;
    end else if ((t_rx_stop || t_pause || sw_stop_rx) && q.rx_on) begin
      d.rx_on = 1'b0;
      d.rx_drain = 1'b1;
      d.rx_tmo = 32'(div) * 32'(RX_TIMEOUT_BITS);
    end else if (q.rx_drain) begin
      // Late bytes are still taken until the window closes
      if (q.rx_tmo == 32'h0) begin
        d.rx_drain = 1'b0;
        d.ev_receiver_timeout_event = 1'b1;
      end else begin
        d.rx_tmo = q.rx_tmo - 32'h1;
      end
    end

    // Receive framing
    if (!q.rx_busy) begin
      if ((q.rx_on || q.rx_drain) && !rx_bit) begin
        d.rx_busy = 1'b1;
        // Start is seen one cycle late, so one less lands on the bit centre
        d.rx_cnt = {1'b0, div[15:1]} - 16'h1;
        d.rx_idx = 4'h0;
      end
    end else if (q.rx_cnt != 16'h0) begin
      d.rx_cnt = q.rx_cnt - 16'h1;
    end else begin
      d.rx_cnt = div - 16'h1;
      d.rx_idx = q.rx_idx + 4'h1;
      if (q.rx_idx == 4'h0) begin
        d.rx_busy = !rx_bit; // Glitch on the start bit is dropped
      end else if (q.rx_idx <= 4'h8) begin
        d.rx_data = {rx_bit, q.rx_data[7:1]};
      end else if (q.rx_idx == 4'h9 && q.cfg[CFG_PARITY_BIT]) begin
        cmp = q.rx_data;
        if (rx_bit != (^cmp ^ q.cfg[CFG_ODD_BIT])) begin
          d.fault[FLT_PARITY_BIT] = 1'b1;
          d.ev_err = 1'b1;
        end
      end else begin
        // Only the first stop bit is checked so the next start is not missed
        stop_ok = rx_bit;
        d.rx_busy = 1'b0;
        push = 1'b1;
        if (!stop_ok) begin
          d.fault[FLT_FRAMING_BIT] = 1'b1;
          d.ev_err = 1'b1;
        end
      end
    end

    // Break: framing fault is seen at the stop bit, at least half a bit time before this fires
    if (rx_bit) begin
      d.low_cnt = 32'h0;
      d.brk_done = 1'b0;
    end else if (q.low_cnt != 32'hffffffff) begin
      d.low_cnt = q.low_cnt + 32'h1;
    end
    if (!rx_bit && !q.brk_done && q.low_cnt > frame_cycles && (q.rx_on || q.rx_drain)) begin
      d.brk_done = 1'b1;
      d.fault[FLT_BREAK_BIT] = 1'b1;
      d.ev_err = 1'b1;
    end

    // Queue: move head into the receive byte, then take the new byte
    if (!d.rxd_val && q.count != 3'h0) begin
      d.rxd_byte = q.fifo[q.rd_ptr];
      d.rxd_val = 1'b1;
      d.ev_rxrdy = 1'b1;
      d.rd_ptr = uafc_next(q.rd_ptr);
      d.count = q.count - 3'h1;
    end
    if (push) begin
      if (d.count == FIFO_DEPTH) begin
        // Full queue: newest slot is overwritten, older bytes kept
        d.fifo[(q.wr_ptr == 3'h0) ? FIFO_DEPTH - 3'h1 : q.wr_ptr - 3'h1] = q.rx_data;
        d.fault[FLT_OVERRUN_BIT] = 1'b1;
        d.ev_err = 1'b1;
      end else begin
        d.fifo[q.wr_ptr] = q.rx_data;
        d.wr_ptr = uafc_next(q.wr_ptr);
        d.count = d.count + 3'h1;
      end
    end

    // Request-to-send
    if (d.count >= RTS_OFF_LEVEL) begin
      d.rts_block = 1'b1;
    end else if (d.count == 3'h0 && !d.rxd_val) begin
      d.rts_block = 1'b0;
    end
    d.rts_n = flow && (!d.rx_on || d.rts_block);

    if (!port_en) begin
      d.tx_busy = 1'b0;
      d.tx_shift = 12'hfff;
      d.rx_busy = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.psel_rts <= PSEL_RESET;
      q.psel_txd <= PSEL_RESET;
      q.psel_cts <= PSEL_RESET;
      q.psel_rxd <= PSEL_RESET;
      q.baud <= BIT_RATE_RESET;
      q.tx_shift <= 12'hfff;
    end else begin
      q <= d;
    end
  end

endmodule // uafc_uart

//--- verification/uafc_uart_chk.sv
// Concurrent checks on the serial port's bus handshake and line timing
`timescale 1ns/1ns
module uafc_uart_chk (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txd_out,
  input wire logic rts_n_out
);
  logic [2:0] idle_q;
  logic [2:0] idle_d;
  // Cycles since software last touched the bus, saturating
  always_comb begin
    idle_d = (idle_q == 3'h7) ? idle_q : idle_q + 3'h1;
    if ((s_axi_arvalid && s_axi_arready) || (s_axi_awvalid && s_axi_awready)) begin
      idle_d = 3'h0;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      idle_q <= 3'h7;
    end else begin
      idle_q <= idle_d;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
  // Bench runs four clocks per bit, so any level lasts at least four cycles
  AST_TX_BIT: assert property ($changed(txd_out) |=> $stable(txd_out)[*3])
    else $error("transmit bit too short");
  AST_RTS_BACK: assert property ($fell(rts_n_out) |-> idle_q < 3'h4)
    else $error("request-to-send returned without a read");
endmodule // uafc_uart_chk

//--- verification/uafc_peer.sv
// Remote serial port: sends frames to the receiver and decodes the transmit line
`timescale 1ns/1ns
module uafc_peer #(
  parameter int BR = 4
) (
  input wire logic core_clk,
  input wire logic txd_out,
  input wire logic rts_n_out,
  output logic rxd_in
);
  logic [7:0] got[$];
  logic [7:0] sh;
  logic bit9;
  initial rxd_in = 1'b1;
  task automatic bit_out(input logic v, input int n);
    rxd_in <= v;
    repeat (n) @(posedge core_clk);
  endtask
  // A nonzero tail sends a low stop bit and keeps the line low that much longer
  task automatic send(input logic [7:0] b, input int tail);
    for (int n = 0; n < 4000 && rts_n_out; n++) @(posedge core_clk);
    if (rts_n_out) begin
      testbench.fails++;
      testbench.give_verdict();
    end
    bit_out(1'b0, BR);
    for (int i = 0; i < 8; i++) bit_out(b[i], BR);
    bit_out(tail == 0, BR + tail);
    bit_out(1'b1, BR);
  endtask
  always begin
    @(negedge txd_out);
    repeat (BR / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BR) @(posedge core_clk);
      sh[i] = txd_out;
    end
    repeat (BR) @(posedge core_clk);
    bit9 = txd_out;
    got.push_back(sh);
  end
endmodule // uafc_peer

//--- verification/testbench.sv
// Register-level test of the flow-controlled serial port against a remote port
`timescale 1ns/1ns
module testbench
  import uafc_pkg::*;
;
  logic core_clk = 1'b0, rstn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cts_n_in = 1'b0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rv;
  logic rxd_in, txd_out, txd_oe_n, rts_n_out, rts_oe_n;
  int fails = 0, samples_checked = 0;
  always #5 core_clk = ~core_clk;
  uafc_uart u_uafc_uart (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd_in,
    .cts_n_in, .txd_out, .txd_oe_n, .rts_n_out, .rts_oe_n);
  uafc_peer #(.BR(4)) u_peer (.core_clk, .txd_out, .rts_n_out, .rxd_in);
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Ready is late on purpose so the slave must hold its answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic done, ta, tw;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid && s_axi_bready;
      rr = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      s_axi_bready <= n > 1 && !done;
    end
    if (!done) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic rd(input logic [11:0] a);
    logic done, ta;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid && s_axi_rready;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      s_axi_rready <= n > 0 && !done;
    end
    if (!done) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task automatic wait_ev(input logic [11:0] a);
    rv = 32'h0;
    for (int n = 0; n < 150 && rv !== 32'h1; n++) rd(a);
    chk(rv, 32'h1);
    if (rv !== 32'h1) give_verdict();
    wr(a, 32'h0);
  endtask
  task automatic rd_byte(input logic [7:0] e);
    rd_chk(OFF_EV_RX_READY, 32'h1);
    wr(OFF_EV_RX_READY, 32'h0);
    rd_chk(OFF_RECEIVE_BYTE, {24'h0, e});
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    chk(32'(txd_oe_n), 32'h1);
    chk(32'(rts_oe_n), 32'h1);
    rd_chk(OFF_BIT_RATE, 32'h364);
    rd_chk(OFF_PORT_ENABLE, 32'h0);
    rd_chk(12'h7f0, 32'h0);
    chk(32'(rr), 32'h2);
    wr(12'h7f4, 32'h1);
    chk(32'(rr), 32'h2);
    wr(OFF_BIT_RATE, 32'h4);
    for (int i = 0; i < 4; i++) wr(OFF_PIN_SEL_REQ + 12'(4 * i), 32'h0);
    wr(OFF_PORT_ENABLE, 32'h4);
    chk(32'(txd_oe_n), 32'h0);
    chk(32'(rts_oe_n), 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(k == 2 ? OFF_TASK_PAUSE : OFF_TASK_TX_STOP, 32'h1);
      wr(OFF_TRANSMIT_BYTE, 32'h5a + k);
      repeat (80) @(posedge core_clk);
      chk(32'(u_peer.got.size()), 32'(k));
      wr(OFF_TASK_TX_START, 32'h1);
      wait_ev(OFF_EV_TX_READY);
      chk(32'(u_peer.got[k]), 32'h5a + k);
    end
    wr(OFF_TRANSMIT_BYTE, 32'hc3);
    repeat (12) @(posedge core_clk);
    wr(OFF_TASK_PAUSE, 32'h1);
    wait_ev(OFF_EV_TX_READY);
    chk(32'(u_peer.got[3]), 32'hc3);
    wr(OFF_TASK_TX_START, 32'h1);
    wr(OFF_FRAME_FLOW, 32'h1);
    cts_n_in <= 1'b1;
    wr(OFF_TRANSMIT_BYTE, 32'h3c);
    repeat (80) @(posedge core_clk);
    chk(32'(u_peer.got.size()), 32'h4);
    rd_chk(OFF_EV_PEER_NOT_CLEAR, 32'h1);
    cts_n_in <= 1'b0;
    wait_ev(OFF_EV_TX_READY);
    wr(OFF_TRANSMIT_BYTE, 32'h96);
    repeat (8) @(posedge core_clk);
    cts_n_in <= 1'b1;
    wait_ev(OFF_EV_TX_READY);
    chk(32'(u_peer.got[5]), 32'h96);
    wr(OFF_FRAME_FLOW, 32'h2);
    wr(OFF_TRANSMIT_BYTE, 32'h69);
    wait_ev(OFF_EV_TX_READY);
    chk(32'(u_peer.got[6]), 32'h69);
    chk(32'(u_peer.bit9), 32'h0);
    cts_n_in <= 1'b0;
    wr(OFF_FRAME_FLOW, 32'h0);
    u_peer.send(8'h77, 0);
    rd_chk(OFF_EV_RX_READY, 32'h0);
    wr(OFF_TASK_RX_START, 32'h1);
    for (int i = 0; i < 8; i++) u_peer.send(8'(8'h40 + i), 0);
    chk(32'(rts_n_out), 32'h0);
    rd_chk(OFF_FAULT_CAUSE, 32'h1);
    wr(OFF_FAULT_CAUSE, 32'hf);
    for (int i = 0; i < 7; i++) rd_byte(i == 6 ? 8'h47 : 8'(8'h40 + i));
    wait_ev(OFF_EV_LINE_FAULT);
    // Even parity on a zero byte wants a low ninth bit; the peer sends its high stop there
    wr(OFF_FRAME_FLOW, 32'h2);
    u_peer.send(8'h00, 0);
    wait_ev(OFF_EV_LINE_FAULT);
    rd_chk(OFF_FAULT_CAUSE, 32'h2);
    wr(OFF_FAULT_CAUSE, 32'hf);
    rd_byte(8'h00);
    wr(OFF_FRAME_FLOW, 32'h1);
    for (int i = 0; i < 3; i++) begin
      u_peer.send(8'(8'h20 + i), 0);
      chk(32'(rts_n_out), 32'(i == 2));
    end
    rd_byte(8'h20);
    chk(32'(rts_n_out), 32'h1);
    rd_byte(8'h21);
    rd_byte(8'h22);
    repeat (4) @(posedge core_clk);
    chk(32'(rts_n_out), 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(k == 0 ? OFF_TASK_RX_STOP : OFF_TASK_PAUSE, 32'h1);
      chk(32'(rts_n_out), 32'h1);
      rd_chk(OFF_EV_RX_TIMEOUT, 32'h0);
      wait_ev(OFF_EV_RX_TIMEOUT);
      wr(OFF_TASK_RX_START, 32'h1);
    end
    wr(OFF_FRAME_FLOW, 32'h0);
    u_peer.send(8'h00, 48);
    wait_ev(OFF_EV_LINE_FAULT);
    rd_chk(OFF_FAULT_CAUSE, 32'hc);
    give_verdict();
  end
endmodule // testbench
bind uafc_uart uafc_uart_chk u_uafc_uart_chk (.core_clk, .rstn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .txd_out,
  .rts_n_out);
